// >>> hdl/pabm_pin_ctl.sv
`timescale 1ns/1ps
// Generic override combiner for one pad; purely combinational.
module pabm_pin_ctl (
  // Port register bits and global state
  input wire logic pin_dir_bit_i,
  input wire logic pin_out_bit_i,
  input wire logic global_pullup_disable_i,
  input wire logic sleep_i,
  // Override signals
  input wire logic pullup_ovr_en_i,
  input wire logic pullup_ovr_val_i,
  input wire logic dir_ovr_en_i,
  input wire logic dir_ovr_val_i,
  input wire logic value_ovr_en_i,
  input wire logic value_ovr_val_i,
  input wire logic din_enable_ovr_en_i,
  input wire logic din_enable_ovr_val_i,
  // Pad controls
  output logic oe_o,
  output logic out_o,
  output logic pu_o,
  output logic die_o
);
  always_comb begin
    if (pullup_ovr_en_i) begin
      pu_o = pullup_ovr_val_i;
    end else begin
      pu_o = ({pin_dir_bit_i, pin_out_bit_i, global_pullup_disable_i} ==
              pabm_pkg::PU_PATTERN);
    end
    oe_o = dir_ovr_en_i ? dir_ovr_val_i : pin_dir_bit_i;
    out_o = (value_ovr_en_i && oe_o) ? value_ovr_val_i :
            pin_out_bit_i;
    die_o = din_enable_ovr_en_i ? din_enable_ovr_val_i : ~sleep_i;
  end
endmodule

// >>> hdl/pabm_pkg.sv
package pabm_pkg;
  // Widths of the two ports.
  localparam int PORTA_W = 4;
  localparam int PORTB_W = 8;
  // Pin positions on the 8-bit port.
  localparam int B_SS = 2;
  localparam int B_MOSI = 3;
  localparam int B_MISO = 4;
  localparam int B_SCK = 5;
  localparam int B_EXT_CLK = 6;
  localparam int B_XTAL = 7;
  localparam int B_CMP_A = 1;
  localparam int B_CMP_B = 2;
  // Pin positions on the 4-bit port for the analog channels.
  localparam int A_CH6 = 0;
  localparam int A_CH7 = 1;
  // Pin-change source numbering.
  localparam int PCS_A_BASE = 24;
  localparam int PCS_B_BASE = 0;
  // Pull-up enable pattern for {dir, out, global disable}.
  localparam logic [2:0] PU_PATTERN = 3'h2;
  // Reset values of the registered pad controls.
  localparam logic RST_OE = 1'h0;
  localparam logic RST_OUT = 1'h0;
  localparam logic RST_PU = 1'h0;
  localparam logic RST_DIE = 1'h0;
  // Reset value of the SPI slave-active flag.
  localparam logic RST_SPI_ACT = 1'h0;
endpackage

// >>> hdl/pabm_port_mux.sv
`timescale 1ns/1ps
module pabm_port_mux #(
  parameter int A_W = pabm_pkg::PORTA_W,
  parameter int B_W = pabm_pkg::PORTB_W
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Port register bits and global state
  input wire logic [3:0] a_dir_i,
  input wire logic [3:0] a_out_i,
  input wire logic [7:0] b_dir_i,
  input wire logic [7:0] b_out_i,
  input wire logic global_pullup_disable_i,
  input wire logic sleep_i,
  // Pad inputs after the Schmitt trigger
  input wire logic [3:0] a_pad_i,
  input wire logic [7:0] b_pad_i,
  // Pin-change masks and group enables
  input wire logic [3:0] a_pc_mask_i,
  input wire logic [7:0] b_pc_mask_i,
  input wire logic pin_change_group3_enable_i,
  input wire logic pin_change_group0_enable_i,
  // Converter digital disables
  input wire logic chan6_digital_disable_i,
  input wire logic chan7_digital_disable_i,
  // Clock selection
  input wire logic ext_clock_sel_i,
  input wire logic xtal_clock_sel_i,
  // SPI
  input wire logic spi_en_i,
  input wire logic spi_master_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_slave_out_i,
  input wire logic spi_master_out_i,
  // Timer 1 compare outputs
  input wire logic timer1_cmp_a_en_i,
  input wire logic timer1_cmp_a_out_i,
  input wire logic timer1_cmp_b_en_i,
  input wire logic timer1_cmp_b_out_i,
  // Pad controls
  output logic [3:0] a_oe_o,
  output logic [3:0] a_drv_o,
  output logic [3:0] a_pu_o,
  output logic [3:0] a_die_o,
  output logic [7:0] b_oe_o,
  output logic [7:0] b_drv_o,
  output logic [7:0] b_pu_o,
  output logic [7:0] b_die_o,
  // Readback of port registers and pins
  output logic [7:0] b_dir_rd_o,
  output logic [7:0] b_out_rd_o,
  output logic [7:0] b_pin_rd_o,
  // Peripheral-side inputs
  output logic [27:24] pin_change_source_a_o,
  output logic [7:0] pin_change_source_b_o,
  output logic [1:0] adc_chan_sel_o,
  output logic ext_clock_in_o,
  output logic spi_sck_in_o,
  output logic spi_mosi_in_o,
  output logic spi_miso_in_o,
  output logic spi_slave_active_o
);
  // The pin roles are fixed per bit, so other widths cannot be served.
  if (A_W != 4 || B_W != 8) begin : g_bad_width
    $error("pabm_port_mux serves only a 4-bit and an 8-bit port");
  end

  logic spi_slave;
  logic spi_mst;
  logic [3:0] a_oe_c, a_drv_c, a_pu_c, a_die_c;
  logic [7:0] b_oe_c, b_drv_c, b_pu_c, b_die_c;
  logic [7:0] b_pu_ovr_en, b_pu_ovr_val, b_dir_ovr_en;
  logic [7:0] b_val_ovr_en, b_val_ovr_val, b_din_ovr_en, b_din_ovr_val;
  logic [3:0] a_din_ovr_en;
  logic [7:0] clk_pins;
  logic [7:0] b_din;
  logic [3:0] a_din;
  logic [3:0] next_a_oe, next_a_drv, next_a_pu, next_a_die;
  logic [7:0] next_b_oe, next_b_drv, next_b_pu, next_b_die;
  logic [7:0] next_b_dir_rd, next_b_out_rd, next_b_pin_rd;
  logic [3:0] next_pcs_a;
  logic [7:0] next_pcs_b;
  logic [1:0] next_chan;
  logic next_ext_clk, next_sck, next_mosi, next_miso, next_spi_act;

  assign spi_slave = spi_en_i & ~spi_master_i;
  assign spi_mst = spi_en_i & spi_master_i;

  // Override terms for each pin, straight from the peripheral state.
  always_comb begin
    b_pu_ovr_en = 8'h00;
    b_pu_ovr_val = 8'h00;
    b_dir_ovr_en = 8'h00;
    b_val_ovr_en = 8'h00;
    b_val_ovr_val = 8'h00;
    b_din_ovr_en = b_pc_mask_i & {8{pin_change_group0_enable_i}};
    // A forced input keeps the ordinary pull-up pattern.
    for (int i = pabm_pkg::B_SS; i <= pabm_pkg::B_SCK; i++) begin
      b_pu_ovr_val[i] = b_out_i[i] & ~global_pullup_disable_i;
    end
    for (int i = pabm_pkg::B_SS; i <= pabm_pkg::B_SCK; i++) begin
      if (i != pabm_pkg::B_MISO) begin
        b_pu_ovr_en[i] = spi_slave;
        b_dir_ovr_en[i] = spi_slave;
      end
    end
    b_pu_ovr_en[pabm_pkg::B_MISO] = spi_mst;
    b_dir_ovr_en[pabm_pkg::B_MISO] = spi_mst;
    b_val_ovr_en[pabm_pkg::B_SCK] = spi_mst;
    b_val_ovr_val[pabm_pkg::B_SCK] = spi_sck_out_i;
    b_val_ovr_en[pabm_pkg::B_MOSI] = spi_mst;
    b_val_ovr_val[pabm_pkg::B_MOSI] = spi_master_out_i;
    b_val_ovr_en[pabm_pkg::B_MISO] = spi_slave;
    b_val_ovr_val[pabm_pkg::B_MISO] = spi_slave_out_i;
    // Compares drive only when software sets the direction bit.
    b_val_ovr_en[pabm_pkg::B_CMP_B] = timer1_cmp_b_en_i;
    b_val_ovr_val[pabm_pkg::B_CMP_B] = timer1_cmp_b_out_i;
    b_val_ovr_en[pabm_pkg::B_CMP_A] = timer1_cmp_a_en_i;
    b_val_ovr_val[pabm_pkg::B_CMP_A] = timer1_cmp_a_out_i;
    clk_pins = 8'h00;
    clk_pins[pabm_pkg::B_EXT_CLK] = ext_clock_sel_i;
    clk_pins[pabm_pkg::B_XTAL] = xtal_clock_sel_i;
    // Clock pins are taken from the port entirely.
    for (int i = pabm_pkg::B_EXT_CLK; i <= pabm_pkg::B_XTAL; i++) begin
      if (clk_pins[i]) begin
        b_pu_ovr_en[i] = 1'b1;
        b_dir_ovr_en[i] = 1'b1;
        b_din_ovr_en[i] = 1'b1;
      end
    end
    // A selected clock pin holds its digital input off; a pin-change-enabled pin forces it on.
    b_din_ovr_val = ~clk_pins;
    a_din_ovr_en = a_pc_mask_i & {4{pin_change_group3_enable_i}};
    a_din_ovr_en[pabm_pkg::A_CH7] = a_din_ovr_en[pabm_pkg::A_CH7] |
                                    chan7_digital_disable_i;
    a_din_ovr_en[pabm_pkg::A_CH6] = a_din_ovr_en[pabm_pkg::A_CH6] |
                                    chan6_digital_disable_i;
  end

  for (genvar g = 0; g < B_W; g++) begin : g_b
    pabm_pin_ctl u_pin (
      .pin_dir_bit_i(b_dir_i[g]),
      .pin_out_bit_i(b_out_i[g]),
      .global_pullup_disable_i(global_pullup_disable_i),
      .sleep_i(sleep_i),
      .pullup_ovr_en_i(b_pu_ovr_en[g]),
      .pullup_ovr_val_i(b_pu_ovr_val[g]),
      .dir_ovr_en_i(b_dir_ovr_en[g]),
      .dir_ovr_val_i(1'b0),
      .value_ovr_en_i(b_val_ovr_en[g]),
      .value_ovr_val_i(b_val_ovr_val[g]),
      .din_enable_ovr_en_i(b_din_ovr_en[g]),
      .din_enable_ovr_val_i(b_din_ovr_val[g]),
      .oe_o(b_oe_c[g]),
      .out_o(b_drv_c[g]),
      .pu_o(b_pu_c[g]),
      .die_o(b_die_c[g])
    );
  end
  for (genvar g = 0; g < A_W; g++) begin : g_a
    pabm_pin_ctl u_pin (
      .pin_dir_bit_i(a_dir_i[g]),
      .pin_out_bit_i(a_out_i[g]),
      .global_pullup_disable_i(global_pullup_disable_i),
      .sleep_i(sleep_i),
      .pullup_ovr_en_i(1'b0),
      .pullup_ovr_val_i(1'b0),
      .dir_ovr_en_i(1'b0),
      .dir_ovr_val_i(1'b0),
      .value_ovr_en_i(1'b0),
      .value_ovr_val_i(1'b0),
      .din_enable_ovr_en_i(a_din_ovr_en[g]),
      .din_enable_ovr_val_i(1'b1),
      .oe_o(a_oe_c[g]),
      .out_o(a_drv_c[g]),
      .pu_o(a_pu_c[g]),
      .die_o(a_die_c[g])
    );
  end

  always_comb begin
    a_din = a_pad_i & a_die_c;
    b_din = b_pad_i & b_die_c;
    next_a_oe = a_oe_c;
    next_a_drv = a_drv_c;
    next_a_pu = a_pu_c;
    next_a_die = a_die_c;
    next_b_oe = b_oe_c;
    next_b_drv = b_drv_c;
    next_b_pu = b_pu_c;
    next_b_die = b_die_c;
    next_b_dir_rd = b_dir_i & ~clk_pins;
    next_b_out_rd = b_out_i & ~clk_pins;
    next_b_pin_rd = b_din & ~clk_pins;
    next_pcs_a = a_din;
    next_pcs_b = b_din & ~clk_pins;
    // Channel select bits: bit 0 for channel 6, bit 1 for channel 7.
    next_chan = {chan7_digital_disable_i, chan6_digital_disable_i};
    next_ext_clk = b_pad_i[pabm_pkg::B_EXT_CLK] & ext_clock_sel_i;
    next_sck = b_din[pabm_pkg::B_SCK];
    next_mosi = b_din[pabm_pkg::B_MOSI];
    next_miso = b_din[pabm_pkg::B_MISO];
    next_spi_act = spi_slave & ~b_pad_i[pabm_pkg::B_SS];
  end

  // Pad controls are registered to keep every output on a flop; this adds
  // one cycle of latency after the combinational override path.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      a_oe_o <= {4{pabm_pkg::RST_OE}};
      a_drv_o <= {4{pabm_pkg::RST_OUT}};
      a_pu_o <= {4{pabm_pkg::RST_PU}};
      a_die_o <= {4{pabm_pkg::RST_DIE}};
      b_oe_o <= {8{pabm_pkg::RST_OE}};
      b_drv_o <= {8{pabm_pkg::RST_OUT}};
      b_pu_o <= {8{pabm_pkg::RST_PU}};
      b_die_o <= {8{pabm_pkg::RST_DIE}};
      b_dir_rd_o <= 8'h00;
      b_out_rd_o <= 8'h00;
      b_pin_rd_o <= 8'h00;
      pin_change_source_a_o <= 4'h0;
      pin_change_source_b_o <= 8'h00;
      adc_chan_sel_o <= 2'h0;
      ext_clock_in_o <= 1'b0;
      spi_sck_in_o <= 1'b0;
      spi_mosi_in_o <= 1'b0;
      spi_miso_in_o <= 1'b0;
      spi_slave_active_o <= pabm_pkg::RST_SPI_ACT;
    end else begin
      a_oe_o <= next_a_oe;
      a_drv_o <= next_a_drv;
      a_pu_o <= next_a_pu;
      a_die_o <= next_a_die;
      b_oe_o <= next_b_oe;
      b_drv_o <= next_b_drv;
      b_pu_o <= next_b_pu;
      b_die_o <= next_b_die;
      b_dir_rd_o <= next_b_dir_rd;
      b_out_rd_o <= next_b_out_rd;
      b_pin_rd_o <= next_b_pin_rd;
      pin_change_source_a_o <= next_pcs_a;
      pin_change_source_b_o <= next_pcs_b;
      adc_chan_sel_o <= next_chan;
      ext_clock_in_o <= next_ext_clk;
      spi_sck_in_o <= next_sck;
      spi_mosi_in_o <= next_mosi;
      spi_miso_in_o <= next_miso;
      spi_slave_active_o <= next_spi_act;
    end
  end

  a_slave_sck_in: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_slave |=> !b_oe_o[pabm_pkg::B_SCK])
    else $error("SCK drives while SPI is slave");
  a_master_miso_in: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_mst |=> !b_oe_o[pabm_pkg::B_MISO])
    else $error("MISO drives while SPI is master");
  a_slave_mosi_in: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_slave |=> !b_oe_o[pabm_pkg::B_MOSI])
    else $error("MOSI drives while SPI is slave");
  a_slave_ss_in: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_slave |=> !b_oe_o[pabm_pkg::B_SS])
    else $error("SS drives while SPI is slave");
  a_slave_active: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_slave_active_o |->
      $past(spi_slave) && !$past(b_pad_i[pabm_pkg::B_SS]))
    else $error("Slave SPI active without select low");
  a_forced_pullup: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    spi_slave |=> b_pu_o[pabm_pkg::B_SCK] ==
      ($past(b_out_i[pabm_pkg::B_SCK]) && !$past(global_pullup_disable_i)))
    else $error("Forced-input SCK pull-up wrong");
  a_clock_readback: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ext_clock_sel_i |=> !b_dir_rd_o[6] && !b_out_rd_o[6] && !b_pin_rd_o[6])
    else $error("Clock pin 6 reads nonzero");
  a_xtal_readback: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    xtal_clock_sel_i |=> !b_dir_rd_o[7] && !b_out_rd_o[7] && !b_pin_rd_o[7])
    else $error("Clock pin 7 reads nonzero");
  a_ch7_die: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    chan7_digital_disable_i |=> a_die_o[pabm_pkg::A_CH7])
    else $error("Channel 7 input enable not overridden");
  a_plain_pullup: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1 |=> a_pu_o[3] == ($past(a_dir_i[3]) == 1'b0 &&
      $past(a_out_i[3]) && !$past(global_pullup_disable_i)))
    else $error("Port A pull-up pattern wrong");
  a_cmp_a_value: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    timer1_cmp_a_en_i && b_dir_i[1] |=>
      b_drv_o[1] == $past(timer1_cmp_a_out_i))
    else $error("Compare A value not on pad");
endmodule

// >>> sim/pabm_periph_model.sv
`timescale 1ns/1ps
// Stand-in for the SPI and timer 1 output logic that feeds the pin mux.
module pabm_periph_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Peripheral outputs toward the mux
  output logic spi_sck_out_o,
  output logic spi_slave_out_o,
  output logic spi_master_out_o,
  output logic timer1_cmp_a_out_o,
  output logic timer1_cmp_b_out_o
);
  logic [4:0] cnt;
  // Values move on the falling edge, so each one is steady at the rising
  // edge that samples it; every output keeps changing to expose stale use.
  always @(negedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt <= 5'h00;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end
  assign spi_sck_out_o = cnt[0];
  assign spi_slave_out_o = cnt[1] ^ cnt[0];
  assign spi_master_out_o = ~cnt[1];
  assign timer1_cmp_a_out_o = cnt[2] ^ cnt[0];
  assign timer1_cmp_b_out_o = ~cnt[0];
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i, global_pullup_disable_i, sleep_i;
  logic [3:0] a_dir_i, a_out_i, a_pad_i, a_pc_mask_i;
  logic [7:0] b_dir_i, b_out_i, b_pad_i, b_pc_mask_i;
  logic pin_change_group3_enable_i, pin_change_group0_enable_i;
  logic chan6_digital_disable_i, chan7_digital_disable_i;
  logic ext_clock_sel_i, xtal_clock_sel_i, spi_en_i, spi_master_i;
  logic spi_sck_out_i, spi_slave_out_i, spi_master_out_i;
  logic timer1_cmp_a_en_i, timer1_cmp_a_out_i;
  logic timer1_cmp_b_en_i, timer1_cmp_b_out_i;
  logic [3:0] a_oe_o, a_drv_o, a_pu_o, a_die_o;
  logic [7:0] b_oe_o, b_drv_o, b_pu_o, b_die_o;
  logic [7:0] b_dir_rd_o, b_out_rd_o, b_pin_rd_o, pin_change_source_b_o;
  logic [27:24] pin_change_source_a_o;
  logic [1:0] adc_chan_sel_o;
  logic ext_clock_in_o, spi_sck_in_o, spi_mosi_in_o, spi_miso_in_o;
  logic spi_slave_active_o;
  int error_cnt = 0;
  int tests_run = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  pabm_port_mux dut (
    .clk_sys_i, .sys_rst_i, .a_dir_i, .a_out_i, .b_dir_i, .b_out_i,
    .global_pullup_disable_i, .sleep_i, .a_pad_i, .b_pad_i, .a_pc_mask_i,
    .b_pc_mask_i, .pin_change_group3_enable_i, .pin_change_group0_enable_i,
    .chan6_digital_disable_i, .chan7_digital_disable_i, .ext_clock_sel_i,
    .xtal_clock_sel_i, .spi_en_i, .spi_master_i, .spi_sck_out_i,
    .spi_slave_out_i, .spi_master_out_i, .timer1_cmp_a_en_i,
    .timer1_cmp_a_out_i, .timer1_cmp_b_en_i, .timer1_cmp_b_out_i,
    .a_oe_o, .a_drv_o, .a_pu_o, .a_die_o, .b_oe_o, .b_drv_o, .b_pu_o,
    .b_die_o, .b_dir_rd_o, .b_out_rd_o, .b_pin_rd_o, .pin_change_source_a_o,
    .pin_change_source_b_o, .adc_chan_sel_o, .ext_clock_in_o, .spi_sck_in_o,
    .spi_mosi_in_o, .spi_miso_in_o, .spi_slave_active_o
  );

  pabm_periph_model peer (
    .clk_sys_i, .sys_rst_i,
    .spi_sck_out_o(spi_sck_out_i),
    .spi_slave_out_o(spi_slave_out_i),
    .spi_master_out_o(spi_master_out_i),
    .timer1_cmp_a_out_o(timer1_cmp_a_out_i),
    .timer1_cmp_b_out_o(timer1_cmp_b_out_i)
  );

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Checks one falling edge after the inputs were set, while they still
  // hold, so the expectation uses exactly what the rising edge sampled.
  task automatic settle();
    logic slv, mst, npd;
    logic [7:0] frc, clk_m, oe, pu, drv, bdie;
    logic [3:0] adie;
    @(negedge clk_sys_i);
    slv = spi_en_i & ~spi_master_i;
    mst = spi_en_i & spi_master_i;
    npd = ~global_pullup_disable_i;
    clk_m = {xtal_clock_sel_i, ext_clock_sel_i, 6'h00};
    frc = {1'h0, 1'h0, slv, mst, slv, slv, 1'h0, 1'h0};
    oe = b_dir_i & ~frc & ~clk_m;
    pu = ((~b_dir_i & b_out_i) | (frc & b_out_i)) & {8{npd}} & ~clk_m;
    drv = b_out_i;
    if (mst) begin
      drv[5] = spi_sck_out_i;
      drv[3] = spi_master_out_i;
    end
    if (slv) begin
      drv[4] = spi_slave_out_i;
    end
    if (timer1_cmp_b_en_i) begin
      drv[2] = timer1_cmp_b_out_i;
    end
    if (timer1_cmp_a_en_i) begin
      drv[1] = timer1_cmp_a_out_i;
    end
    bdie = ~clk_m & ((b_pc_mask_i & {8{pin_change_group0_enable_i}})
                     | {8{~sleep_i}});
    adie = (a_pc_mask_i & {4{pin_change_group3_enable_i}}) | {4{~sleep_i}}
           | {2'h0, chan7_digital_disable_i, chan6_digital_disable_i};
    cmp("b_oe", oe, b_oe_o);
    cmp("b_pu", pu, b_pu_o);
    cmp("b_drv", drv & oe, b_drv_o & oe);
    cmp("b_die", bdie, b_die_o);
    cmp("a_die", {4'h0, adie}, {4'h0, a_die_o});
    cmp("a_pcs", {4'h0, a_pad_i & adie}, {4'h0, pin_change_source_a_o});
    cmp("b_dir_rd", b_dir_i & ~clk_m, b_dir_rd_o);
    cmp("b_out_rd", b_out_i & ~clk_m, b_out_rd_o);
    cmp("b_pin_rd", b_pad_i & bdie, b_pin_rd_o);
    cmp("adc_sel", {6'h00, chan7_digital_disable_i, chan6_digital_disable_i},
        {6'h00, adc_chan_sel_o});
    cmp("a_oe_pu", {a_dir_i, ~a_dir_i & a_out_i & {4{npd}}},
        {a_oe_o, a_pu_o});
    cmp("a_drv", {4'h0, a_out_i & a_dir_i},
        {4'h0, a_drv_o & a_dir_i});
    cmp("slave_act", {7'h00, slv & ~b_pad_i[2]},
        {7'h00, spi_slave_active_o});
    cmp("b_pcs", b_pad_i & bdie, pin_change_source_b_o);
    cmp("periph_in", {4'h0, b_pad_i[6] & ext_clock_sel_i,
        b_pad_i[5] & bdie[5], b_pad_i[3] & bdie[3], b_pad_i[4] & bdie[4]},
        {4'h0, ext_clock_in_o, spi_sck_in_o, spi_mosi_in_o,
         spi_miso_in_o});
  endtask

  initial begin
    sys_rst_i = 1'h1;
    {a_dir_i, a_out_i, a_pad_i, b_dir_i, b_out_i, b_pad_i} = '1;
    {global_pullup_disable_i, sleep_i, a_pc_mask_i, b_pc_mask_i} = '0;
    {pin_change_group3_enable_i, pin_change_group0_enable_i} = '0;
    {chan6_digital_disable_i, chan7_digital_disable_i} = '0;
    {ext_clock_sel_i, xtal_clock_sel_i, spi_en_i, spi_master_i} = '0;
    {timer1_cmp_a_en_i, timer1_cmp_b_en_i} = '0;
    @(negedge clk_sys_i);
    cmp("rst_b", 8'h00, b_oe_o | b_pu_o | b_die_o | b_pin_rd_o);
    cmp("rst_a", 8'h00, {a_oe_o | a_pu_o, a_die_o | a_drv_o});
    @(negedge clk_sys_i);
    sys_rst_i = 1'h0;
    @(negedge clk_sys_i);
    for (int k = 0; k < 8; k++) begin
      b_dir_i = 8'h5a ^ {8{k[0]}};
      b_out_i = 8'h3c ^ {8{k[1]}};
      global_pullup_disable_i = k[2];
      sleep_i = k[1];
      {a_dir_i, a_out_i} = {b_dir_i[3:0], b_out_i[7:4]};
      b_pad_i = 8'ha5 ^ {8{k[0]}};
      a_pad_i = ~b_pad_i[3:0];
      settle();
    end
    $display("test gpio done");
    {b_dir_i, b_out_i, sleep_i, global_pullup_disable_i} = 18'h3fffc;
    for (int m = 0; m < 6; m++) begin
      spi_en_i = (m > 1);
      spi_master_i = (m > 3);
      b_pad_i = {5'h1f, m[0], 2'h3};
      settle();
      settle();
    end
    $display("test spi done");
    {spi_en_i, b_dir_i} = {1'h0, 8'h06};
    for (int t = 0; t < 8; t++) begin
      {timer1_cmp_b_en_i, timer1_cmp_a_en_i} = t[2:1];
      settle();
    end
    $display("test timer done");
    {b_dir_i, b_pad_i} = 16'hffff;
    for (int c = 1; c < 4; c++) begin
      {xtal_clock_sel_i, ext_clock_sel_i} = c[1:0];
      settle();
    end
    {xtal_clock_sel_i, ext_clock_sel_i} = 2'h0;
    $display("test clock pins done");
    {sleep_i, a_pc_mask_i, b_pc_mask_i, a_pad_i} = 17'h15f0f;
    for (int k = 0; k < 8; k++) begin
      pin_change_group3_enable_i = k[0];
      pin_change_group0_enable_i = ~k[0];
      chan6_digital_disable_i = k[1];
      chan7_digital_disable_i = k[2];
      settle();
    end
    $display("test port a done");
    complete_run();
  end
endmodule
